// file: verilog/eeprom_host_pkg.sv
package eeprom_host_pkg;
    // clock
    localparam int CLK_PERIOD_NS         = 25;
    // array shape
    localparam int ADDR_W                = 15;
    localparam int DATA_W                = 8;
    localparam int COL_W                 = 6;
    localparam int PAGE_BYTES            = 64;
    localparam int TOGGLE_BIT            = 6;
    localparam int POLL_BIT              = 7;
    // printed times, in their own units
    localparam int WE_PULSE_NS           = 200;
    localparam int DATA_SETUP_NS         = 70;
    localparam int ADDR_HOLD_NS          = 50;
    localparam int ACCESS_NS             = 120;
    localparam int BUSY_DELAY_NS         = 120;
    localparam int BYTE_LOAD_GAP_MIN_NS  = 300;
    localparam int BYTE_LOAD_GAP_MAX_US  = 30;
    localparam int LOAD_WINDOW_US        = 100;
    localparam int PROGRAM_TIME_MS       = 10;
    localparam int RESTART_DELAY_NS      = 0;
    // least times round up, longest times round down
    localparam int WE_PULSE_CYC   = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_HOLD_CYC  = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC     = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_DELAY_CYC = (BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_MIN_CYC    =
        (BYTE_LOAD_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_MAX_CYC    = (BYTE_LOAD_GAP_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int LOAD_WINDOW_CYC =
        (LOAD_WINDOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYC_DEF =
        (PROGRAM_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_CYC    = RESTART_DELAY_NS / CLK_PERIOD_NS;
    // counter widths
    localparam int TMR_W          = 8;
    localparam int WAIT_W         = 19;

    // how the end of programming is found
    typedef enum logic [1:0] {
        DONE_FIXED,
        DONE_BUSY,
        DONE_TOGGLE
    } done_mode_type;

    // one request from the user side
    typedef struct packed {
        logic                  wr;
        done_mode_type         mode;
        logic [ADDR_W-1:0]     addr;
        logic [COL_W-1:0]      last_col;
    } cmd_type;

    // one byte put into the page buffer
    typedef struct packed {
        logic [COL_W-1:0]      col;
        logic [DATA_W-1:0]     data;
    } load_type;

    // pins driven toward the memory
    typedef struct packed {
        logic                  ce_n;
        logic                  oe_n;
        logic                  we_n;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     dq_out;
        logic                  dq_oe;
        logic                  program_guard_n;
    } pin_out_type;

    // pins read back from the memory
    typedef struct packed {
        logic [DATA_W-1:0]     dq_in;
        logic                  rdy_busy;
    } pin_in_type;
endpackage

// file: verilog/page_buf.sv
`timescale 1ns/10ps
// one page of write data, read port registered
module page_buf
    import eeprom_host_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              wr_en,
    input  wire load_type          wr_load,
    input  wire logic [COL_W-1:0]  rd_col,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [PAGE_BYTES];  // storage, no reset needed

    // write side
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_load.col] <= wr_load.data;
        end
    end

    // read side, one cycle of latency
    always_ff @(posedge clk_sys) begin
        rd_data <= mem[rd_col];
    end
endmodule // page_buf

// file: verilog/eeprom_host.sv
`timescale 1ns/10ps
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int PROGRAM_CYC = PROGRAM_CYC_DEF  // 10 ms at 40 MHz
) (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              load_valid,
    input  wire load_type          load,
    output logic                   load_ready,
    input  wire logic              cmd_valid,
    input  wire cmd_type           cmd,
    output logic                   cmd_ready,
    output logic                   done,
    output logic                   timed_out,
    output logic      [DATA_W-1:0] rd_data,
    output pin_out_type            pins,
    input  wire pin_in_type        pins_in
);
    typedef enum logic [3:0] {
        S_IDLE, S_WR_SETUP, S_WR_PULSE, S_WR_HOLD, S_FIX_WAIT,
        S_BUSY_WAIT, S_POLL_RD, S_POLL_GAP, S_RD, S_DONE
    } state_type;

    // the wait covers the load window plus the whole program time
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(LOAD_WINDOW_CYC + PROGRAM_CYC - 1);

    state_type          state_q, state_d;        // sequencer
    logic [TMR_W-1:0]   tmr_q;                   // short phase timer, counts down
    logic [WAIT_W-1:0]  wait_q;                  // long wait / watchdog, counts up
    logic [COL_W-1:0]   col_q;                   // column being loaded
    logic [COL_W-1:0]   last_col_q;              // final column of the load
    logic [COL_W-1:0]   first_col_q;             // first column, reused for polls
    logic [ADDR_W-COL_W-1:0] page_q;             // page held through the load
    done_mode_type      mode_q;                  // completion method
    logic               tog_now_q, tog_prev_q;   // last two toggle samples
    logic [1:0]         seen_q;                  // samples taken, saturating
    logic [DATA_W-1:0]  buf_data;                // registered buffer read
    logic               tmr_done;                // phase timer expired
    logic               wait_end;                // long wait expired
    logic               tog_match;               // two reads agree
    logic [TMR_W-1:0]   tmr_load;                // timer value for next phase
    logic               ce_n_q, oe_n_q, we_n_q;  // registered strobe levels
    logic               dq_oe_q, guard_n_q;      // registered drive enable and guard

    assign tmr_done  = (tmr_q == '0);
    assign wait_end  = (wait_q == WAIT_LAST);
    assign tog_match = (seen_q == 2'h2) && (tog_now_q == tog_prev_q);
    assign cmd_ready = (state_q == S_IDLE);
    // the buffer may only change while no load is in flight
    assign load_ready = (state_q == S_IDLE);
    assign done      = (state_q == S_DONE);

    page_buf u_buf (
        .clk_sys (clk_sys),
        .wr_en   (load_valid && load_ready),
        .wr_load (load),
        .rd_col  (col_q),
        .rd_data (buf_data)
    );

    // next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (cmd_valid) begin
                    state_d = cmd.wr ? S_WR_SETUP : S_RD;
                end
            end
            S_WR_SETUP: if (tmr_done) state_d = S_WR_PULSE;
            S_WR_PULSE: if (tmr_done) state_d = S_WR_HOLD;
            S_WR_HOLD: begin
                // bytes follow back to back, far inside the load gap limit
                if (tmr_done && col_q != last_col_q) begin
                    state_d = S_WR_SETUP;
                end else if (tmr_done) begin
                    unique case (mode_q)
                        DONE_FIXED:  state_d = S_FIX_WAIT;
                        DONE_BUSY:   state_d = S_BUSY_WAIT;
                        DONE_TOGGLE: state_d = S_POLL_RD;
                        default:     state_d = S_FIX_WAIT;
                    endcase
                end
            end
            // no status used: sit out the full time
            S_FIX_WAIT: if (wait_end) state_d = S_DONE;
            // ready seen: finish at once, no extra delay
            S_BUSY_WAIT: begin
                if ((tmr_done && pins_in.rdy_busy) || wait_end) begin
                    state_d = S_DONE;
                end
            end
            S_POLL_RD: if (tmr_done) state_d = S_POLL_GAP;
            // agreement or the long wait expiring ends the poll, never a particular value
            S_POLL_GAP: begin
                state_d = (tog_match || wait_end) ? S_DONE : S_POLL_RD;
            end
            S_RD:       if (tmr_done) state_d = S_DONE;
            S_DONE:     state_d = S_IDLE;
            default:    state_d = S_IDLE;
        endcase
    end

    // phase length of the state being entered
    always_comb begin
        unique case (state_d)
            S_WR_SETUP:  tmr_load = TMR_W'(DATA_SETUP_CYC - 1);
            S_WR_PULSE:  tmr_load = TMR_W'(WE_PULSE_CYC - 1);
            S_WR_HOLD:   tmr_load = TMR_W'(ADDR_HOLD_CYC - 1);
            S_BUSY_WAIT: tmr_load = TMR_W'(BUSY_DELAY_CYC - 1);
            S_POLL_RD:   tmr_load = TMR_W'(ACCESS_CYC - 1);
            S_RD:        tmr_load = TMR_W'(ACCESS_CYC - 1);
            default:     tmr_load = '0;
        endcase
    end

    // sequencer register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // phase timer, reloaded on every state change
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tmr_q <= '0;
        end else if (state_d != state_q) begin
            tmr_q <= tmr_load;
        end else if (!tmr_done) begin
            tmr_q <= tmr_q - TMR_W'(1);
        end
    end

    // long wait, started when the last byte is loaded
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wait_q <= '0;
        end else if (state_q == S_WR_HOLD) begin
            wait_q <= '0;
        end else if (!wait_end) begin
            wait_q <= wait_q + WAIT_W'(1);
        end
    end

    // request capture and column stepping; page stays put for the whole load
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            col_q       <= '0;
            last_col_q  <= '0;
            first_col_q <= '0;
            page_q      <= '0;
            mode_q      <= DONE_FIXED;
        end else if (state_q == S_IDLE && cmd_valid) begin
            col_q       <= cmd.addr[COL_W-1:0];
            first_col_q <= cmd.addr[COL_W-1:0];
            last_col_q  <= cmd.last_col;
            page_q      <= cmd.addr[ADDR_W-1:COL_W];
            mode_q      <= cmd.mode;
        end else if (state_q == S_WR_HOLD && state_d == S_WR_SETUP) begin
            col_q       <= col_q + COL_W'(1);
        end else if (state_q == S_WR_HOLD && state_d == S_POLL_RD) begin
            col_q       <= first_col_q;
        end
    end

    // toggle sampling at the end of each poll read
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_q == S_WR_HOLD) begin
            tog_now_q  <= 1'b0;
            tog_prev_q <= 1'b0;
            seen_q     <= 2'h0;
        end else if (state_q == S_POLL_RD && tmr_done) begin
            tog_now_q  <= pins_in.dq_in[TOGGLE_BIT];
            tog_prev_q <= tog_now_q;
            if (seen_q != 2'h2) begin
                seen_q <= seen_q + 2'h1;
            end
        end
    end

    // answer to the user
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data   <= '0;
            timed_out <= 1'b0;
        end else begin
            if ((state_q == S_RD || state_q == S_POLL_RD) && tmr_done) begin
                rd_data <= pins_in.dq_in;
            end
            if (state_q == S_IDLE && cmd_valid) begin
                timed_out <= 1'b0;
            end else if (wait_end && state_d == S_DONE && state_q != S_FIX_WAIT) begin
                timed_out <= 1'b1;
            end
        end
    end

    // registered pin drive, decoded from the next state so it lines up with state_q
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ce_n_q    <= 1'b1;
            oe_n_q    <= 1'b1;
            we_n_q    <= 1'b1;
            dq_oe_q   <= 1'b0;
            guard_n_q <= 1'b0;  // memory held safe through reset
        end else begin
            ce_n_q    <= !(state_d inside {S_WR_SETUP, S_WR_PULSE, S_WR_HOLD,
                                           S_POLL_RD, S_RD});
            oe_n_q    <= !(state_d inside {S_POLL_RD, S_RD});
            we_n_q    <= !(state_d == S_WR_PULSE);
            dq_oe_q   <= (state_d inside {S_WR_SETUP, S_WR_PULSE, S_WR_HOLD});
            guard_n_q <= 1'b1;
        end
    end

    // one driver for the whole bundle; address and data come straight from flip-flops
    always_comb begin
        pins = '{ce_n: ce_n_q, oe_n: oe_n_q, we_n: we_n_q, addr: {page_q, col_q},
                 dq_out: buf_data, dq_oe: dq_oe_q, program_guard_n: guard_n_q};
    end

    // helper: cycles since the previous write strobe fall within one load
    logic [11:0] gap_q;
    logic        in_load_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_q == S_IDLE) begin
            gap_q     <= '0;
            in_load_q <= 1'b0;
        end else if (state_q == S_WR_PULSE && $past(state_q) == S_WR_SETUP) begin
            gap_q     <= 12'h001;
            in_load_q <= 1'b1;
        end else if (gap_q != 12'hfff) begin
            gap_q     <= gap_q + 12'h001;
        end
    end

    sequence s_we_pulse;
        (!pins.we_n) [*8] ##1 pins.we_n;
    endsequence

    property p_we_width;
        @(posedge clk_sys) disable iff (sys_rst) $fell(pins.we_n) |-> s_we_pulse;
    endproperty

    chk_we_pulse_width: assert property (p_we_width)
        else $error("write strobe width is not eight cycles");

    chk_byte_load_gap: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ($fell(pins.we_n) && in_load_q) |-> (gap_q >= 12'(GAP_MIN_CYC))
                                            && (gap_q <= 12'(GAP_MAX_CYC)))
        else $error("byte load gap outside limits");

    // cycles spent in the fixed wait, counted apart from the wait timer
    logic [WAIT_W-1:0] fix_cnt_q;
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_q != S_FIX_WAIT) begin
            fix_cnt_q <= '0;
        end else begin
            fix_cnt_q <= fix_cnt_q + WAIT_W'(1);
        end
    end

    chk_fixed_full_wait: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == S_FIX_WAIT && state_d != S_FIX_WAIT) |-> (fix_cnt_q == WAIT_LAST))
        else $error("fixed wait ended early");

    sequence s_busy_ready;
        state_q == S_BUSY_WAIT && tmr_done && pins_in.rdy_busy;
    endsequence

    chk_busy_restart: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        s_busy_ready |=> done ##1 cmd_ready)
        else $error("ready seen but no prompt completion");

    chk_poll_addr_fixed: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q inside {S_POLL_RD, S_POLL_GAP} && $past(state_q) inside {S_POLL_RD,
         S_POLL_GAP}) |-> $stable(pins.addr))
        else $error("poll address moved");

    chk_toggle_done: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (state_q == S_POLL_GAP && !wait_end) |=> (done == $past(tog_match)))
        else $error("poll end does not follow toggle agreement");
endmodule // eeprom_host

// file: dv/eeprom_model.sv
`timescale 1ns/10ps
// behavioural parallel eeprom seen at its pins, sampled on the host clock
module eeprom_model
    import eeprom_host_pkg::*;
#(
    parameter int WIN  = LOAD_WINDOW_CYC,  // strobe-free span that starts programming
    parameter int PROG = 150               // internal program length in cycles
) (
    input  wire logic              clk_sys,
    input  wire pin_out_type       pins,
    input  wire logic              hang,      // keeps the program cycle open
    output logic      [DATA_W-1:0] dev_dq,
    output logic                   dev_oe,
    output logic                   busy_n,    // open-drain level, 1 = released
    output logic                   prog_busy, // loading or programming
    output int                     proto_err  // host-side rule breaks seen
);
    logic [DATA_W-1:0]       mem [2**ADDR_W];   // array contents
    logic [DATA_W-1:0]       pbuf [PAGE_BYTES]; // page latch
    logic [PAGE_BYTES-1:0]   pvalid;            // columns loaded
    logic [ADDR_W-1:COL_W]   page_q;            // latched page
    logic [COL_W-1:0]        col_q;             // column of current strobe
    logic [DATA_W-1:0]       last_q;            // last byte loaded
    logic [DATA_W-1:0]       dq_q;              // data one cycle back
    logic [ADDR_W-1:0]       poll_addr;         // address of the previous poll read
    logic                    loading;
    logic                    prog_q;
    logic                    tog;
    logic                    we_q;
    logic                    rd_q;
    logic                    poll_seen;
    int                      idle_cnt;
    int                      gap_cnt;
    int                      prog_cnt;
    wire rd = !pins.ce_n && !pins.oe_n && pins.we_n;
    wire wr = !pins.ce_n && !pins.we_n;

    // status reads are busy from the first strobe, else the host could end early
    assign prog_busy = loading || prog_q;
    assign busy_n    = !prog_busy;
    assign dev_oe    = rd;
    assign dev_dq    = prog_busy ? {~last_q[7], tog, last_q[5:0]} : mem[pins.addr];

    // load, program and status sequencing
    always_ff @(posedge clk_sys) begin
        we_q <= wr;
        rd_q <= rd;
        dq_q <= pins.dq_out;
        if (!pins.program_guard_n) begin
            // guard low aborts everything
            loading   <= 1'b0;
            prog_q    <= 1'b0;
            pvalid    <= '0;
            idle_cnt  <= 0;
            poll_seen <= 1'b0;
            proto_err <= 0;
        end else begin
            if (wr && !we_q && !prog_q) begin
                if (!loading) begin
                    page_q    <= pins.addr[ADDR_W-1:COL_W];
                    loading   <= 1'b1;
                    tog       <= 1'b1;
                    poll_seen <= 1'b0;
                end else if (gap_cnt > GAP_MAX_CYC) begin
                    proto_err <= proto_err + 1;
                end
                gap_cnt <= 0;
                col_q   <= pins.addr[COL_W-1:0];
            end else begin
                gap_cnt <= gap_cnt + 1;
            end
            // data is taken as the strobe rises
            if (!wr && we_q && loading) begin
                pbuf[col_q]   <= dq_q;
                pvalid[col_q] <= 1'b1;
                last_q        <= dq_q;
            end
            // only the write strobe restarts the window; polling also takes chip select low
            idle_cnt <= wr ? 0 : idle_cnt + 1;
            if (loading && idle_cnt >= WIN) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (pvalid[i]) begin
                        mem[{page_q, COL_W'(i)}] <= pbuf[i];
                    end
                end
                loading  <= 1'b0;
                prog_q   <= 1'b1;
                pvalid   <= '0;
                prog_cnt <= 0;
            end
            if (prog_q) begin
                prog_cnt <= prog_cnt + 1;
                if (prog_cnt >= PROG && !hang) begin
                    prog_q <= 1'b0;
                end
            end
            if (rd && !rd_q && prog_busy) begin
                if (poll_seen && pins.addr != poll_addr) begin
                    proto_err <= proto_err + 1;
                end
                poll_addr <= pins.addr;
                poll_seen <= 1'b1;
            end
            if (!rd && rd_q && prog_busy) begin
                tog <= ~tog;
            end
        end
    end
endmodule // eeprom_model

// file: dv/eeprom_host_bench.sv
`timescale 1ns/10ps
// self-checking bench: random page writes in every completion mode, read back
module eeprom_host_bench;
    import eeprom_host_pkg::*;
    localparam int PCYC = 200;  // shortened program wait
    logic              clk_sys;
    logic              sys_rst;
    logic              load_valid;
    logic              cmd_valid;
    logic              hang;
    load_type          load;
    cmd_type           cmd;
    logic              load_ready;
    logic              cmd_ready;
    logic              done;
    logic              timed_out;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] dev_dq;
    logic [DATA_W-1:0] bus_q;  // last bus level, inverted when nobody drives
    pin_out_type       pins;
    pin_in_type        pins_in;
    logic              dev_oe;
    logic              busy_n;
    logic              prog_busy;
    int                proto_err;
    int                miscompares;
    int                n_tests;
    int                since_end;  // cycles since the device went idle
    logic [DATA_W-1:0] exp_mem [2**ADDR_W];

    eeprom_host #(.PROGRAM_CYC(PCYC)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .load_valid(load_valid),
        .load(load), .load_ready(load_ready), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .done(done), .timed_out(timed_out),
        .rd_data(rd_data), .pins(pins), .pins_in(pins_in));
    eeprom_model i_mem (
        .clk_sys(clk_sys), .pins(pins), .hang(hang), .dev_dq(dev_dq),
        .dev_oe(dev_oe), .busy_n(busy_n), .prog_busy(prog_busy),
        .proto_err(proto_err));

    // bus resolution; ready line has a pull-up
    assign pins_in = '{dq_in: pins.dq_oe ? pins.dq_out : (dev_oe ? dev_dq : ~bus_q),
                       rdy_busy: busy_n};
    always @(posedge clk_sys) begin
        bus_q     <= pins_in.dq_in;
        since_end <= prog_busy ? 0 : since_end + 1;
    end

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic test_done();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one command, request held until taken; counts cycles to done
    task automatic do_cmd(input cmd_type c, output int cyc);
        cmd       = c;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) tick();
        tick();
        cmd_valid = 1'b0;
        cyc       = 1;
        while (done !== 1'b1 && cyc < 20000) begin
            tick();
            cyc++;
        end
        if (done !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %0t command never finished", $time);
            test_done();
        end
    endtask

    task automatic read_check(input logic [ADDR_W-1:0] a);
        cmd_type c;
        int      cyc;
        c = '{wr: 1'b0, mode: DONE_FIXED, addr: a, last_col: '0};
        do_cmd(c, cyc);
        chk1(cyc == 6, 1'b1, "read latency");
        chk8(rd_data, exp_mem[a], "read back");
    endtask

    task automatic page_write(input done_mode_type m, input int first, input int last,
                              input int page, input logic exp_to);
        cmd_type c;
        int      cyc;
        while (load_ready !== 1'b1) tick();
        for (int i = first; i <= last; i++) begin
            load.col  = 6'(i);
            load.data = 8'($urandom);
            exp_mem[{9'(page), 6'(i)}] = load.data;
            load_valid = 1'b1;
            tick();
        end
        load_valid = 1'b0;
        c = '{wr: 1'b1, mode: m, addr: {9'(page), 6'(first)}, last_col: 6'(last)};
        do_cmd(c, cyc);
        chk1(timed_out, exp_to, "timeout flag");
        if (!exp_to) begin
            chk1(prog_busy, 1'b0, "done while busy");
            if (m == DONE_FIXED) begin
                chk1(cyc >= LOAD_WINDOW_CYC + PCYC, 1'b1, "fixed wait short");
            end else begin
                chk1(since_end <= 24, 1'b1, "slow completion");
            end
        end
        hang = 1'b0;
        while (prog_busy) tick();
        for (int i = first; i <= last; i++) read_check({9'(page), 6'(i)});
    endtask

    // watchdog: about 50k cycles expected, gives up at 80k
    initial begin
        #2000000;
        miscompares++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        int f;
        sys_rst    = 1'b1;
        load_valid = 1'b0;
        cmd_valid  = 1'b0;
        hang       = 1'b0;
        load       = '0;
        cmd        = '0;
        void'($urandom(32'h53f3));
        repeat (10) @(posedge clk_sys);
        #1;
        chk1(pins.program_guard_n, 1'b0, "guard in reset");
        chk1(pins.we_n, 1'b1, "strobe idle in reset");
        sys_rst = 1'b0;
        tick();
        chk1(pins.program_guard_n, 1'b1, "guard after reset");
        // corner cases: one byte, full page, last column
        page_write(DONE_FIXED, 0, 0, 0, 1'b0);
        page_write(DONE_BUSY, 0, 63, 511, 1'b0);
        page_write(DONE_TOGGLE, 63, 63, 85, 1'b0);
        // random pages and ranges in random modes
        repeat (6) begin
            f = $urandom_range(0, 63);
            page_write(done_mode_type'($urandom_range(0, 2)), f, $urandom_range(f, 63),
                       $urandom_range(0, 511), 1'b0);
        end
        // device that never finishes: watchdog in both status modes
        hang = 1'b1;
        page_write(DONE_BUSY, 5, 9, 300, 1'b1);
        hang = 1'b1;
        page_write(DONE_TOGGLE, 2, 2, 17, 1'b1);
        chk1(proto_err == 0, 1'b1, "host load gap or poll address");
        test_done();
    end
endmodule // eeprom_host_bench
